// file: design/irfb_top.sv
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
// How it works
// [R1] external flag sets on its selected edge while the pin is an interrupt input
// [R2] writing zero to a set external flag clears it
// [R3] peripheral and wakeup words only clear; writing one never sets
// [R4] accepting an interrupt clears nothing; flags hold until written zero
// [R5] peripheral word: dt, converter, serial2, tg, tfh, tfl, tc, tb from bit 7
// [R6] direct-transfer flag sets on transfer after sleep while transfer-on is one
// [R7] converter flag sets on conversion done with start flag low
// [R8] serial-two flag sets on transfer complete or abort
// [R9] timer g flag sets on selected edge while its pin is timer input
// [R10] timer f high sets on high match in 8-bit or full match in 16-bit
// [R11] timer f low sets on low match in 8-bit mode only
// [R12] timer c flag sets on counter overflow or underflow
// [R13] timer b flag sets on counter overflow
// [R14] wakeup flag sets on falling edge while pin is a wakeup input
// [R15] writing zero to a set wakeup flag clears it
// [R16] bit 5 of the external word reads one and ignores writes
// [R17] per-pin edge select picks rising or falling for external requests
// [R18] software clears flags only with interrupts masked; here there is no mask and a zero write clears at any time
// [R19] set and clear in one cycle leave the flag set
// [R20] pins synchronised before edge detection; one edge sets once
// [R21] reset clears every request flag
module irfb_top (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [irfb_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [irfb_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [irfb_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [irfb_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// request pins
	input wire logic [irfb_pkg::EXT_N-1:0] ext_request_pin_n_i,
	input wire logic [irfb_pkg::WK_N-1:0] wakeup_pin_n_i,
	// peripheral events, same clock
	input wire logic direct_transfer_on_i,
	input wire logic sleep_transfer_i,
	input wire logic conv_done_i,
	input wire logic conversion_start_flag_i,
	input wire logic serial_two_done_i,
	input wire logic serial_two_abort_i,
	input wire logic timer_g_input_pin_en_i,
	input wire logic timer_g_edge_i,
	input wire logic timer_f_16bit_i,
	input wire logic counter_f_high_match_i,
	input wire logic counter_f_low_match_i,
	input wire logic counter_f_full_match_i,
	input wire logic timer_c_overflow_i,
	input wire logic timer_c_underflow_i,
	input wire logic timer_b_overflow_i,
	// flag outputs
	output logic [irfb_pkg::EXT_N-1:0] ext_req_flag_o,
	output logic [irfb_pkg::REG_W-1:0] peripheral_request_o,
	output logic [irfb_pkg::REG_W-1:0] wakeup_request_o
);
	logic [irfb_pkg::EXT_N-1:0] edge_sel_r;
	logic [irfb_pkg::EXT_N-1:0] ext_pin_en_r;
	logic [irfb_pkg::WK_N-1:0] wake_pin_en_r;
	logic [irfb_pkg::EXT_N-1:0] ext_rise;
	logic [irfb_pkg::EXT_N-1:0] ext_fall;
	logic [irfb_pkg::WK_N-1:0] wk_fall;
	logic [irfb_pkg::EXT_N-1:0] ext_set;
	logic [irfb_pkg::REG_W-1:0] per_set;
	logic [irfb_pkg::WK_N-1:0] wk_set;
	logic wr_fire;
	logic rd_fire;
	logic byte0_wr;
	logic [irfb_pkg::REG_W-1:0] wr_zero;
	logic [irfb_pkg::REG_W-1:0] ext_word;
	logic [irfb_pkg::DATA_W-1:0] rd_word;
	logic rd_hit;
	logic wr_hit;

	// ****************************************
	// pin synchronisers
	// ****************************************
	// [R20] sync then edge detect
	irfb_pin_sync #(.W(irfb_pkg::EXT_N)) u_ext_sync (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.pin_i(ext_request_pin_n_i),
		.rise_o(ext_rise),
		.fall_o(ext_fall)
	);

	irfb_pin_sync #(.W(irfb_pkg::WK_N)) u_wk_sync (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.pin_i(wakeup_pin_n_i),
		.rise_o(),
		.fall_o(wk_fall)
	);

	// ****************************************
	// set conditions
	// ****************************************
	// [R1] [R17] selected edge on enabled pin
	assign ext_set = ext_pin_en_r & ((edge_sel_r & ext_rise) | (~edge_sel_r & ext_fall));
	// [R14] falling edge on wakeup input
	assign wk_set = wake_pin_en_r & wk_fall;

	// [R5] peripheral bit order
	always_comb
	begin
		per_set = irfb_pkg::RST_REG;
		// [R6] transfer after sleep
		per_set[irfb_pkg::BIT_DT] = direct_transfer_on_i && sleep_transfer_i;
		// [R7] conversion done, start flag low
		per_set[irfb_pkg::BIT_AD] = conv_done_i && !conversion_start_flag_i;
		// [R8] complete or abort
		per_set[irfb_pkg::BIT_S2] = serial_two_done_i || serial_two_abort_i;
		// [R9] timer g capture edge
		per_set[irfb_pkg::BIT_TG] = timer_g_input_pin_en_i && timer_g_edge_i;
		// [R10] mode picks the match
		per_set[irfb_pkg::BIT_TFH] = timer_f_16bit_i ? counter_f_full_match_i : counter_f_high_match_i;
		// [R11] low match, 8-bit mode only
		per_set[irfb_pkg::BIT_TFL] = !timer_f_16bit_i && counter_f_low_match_i;
		// [R12] wrap either way
		per_set[irfb_pkg::BIT_TC] = timer_c_overflow_i || timer_c_underflow_i;
		// [R13] overflow wrap
		per_set[irfb_pkg::BIT_TB] = timer_b_overflow_i;
	end

	// ****************************************
	// bus write decode
	// ****************************************
	assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign byte0_wr = wr_fire && s_axi_wstrb[0];
	assign wr_zero = ~s_axi_wdata[irfb_pkg::REG_W-1:0];
	assign wr_hit = (s_axi_awaddr == irfb_pkg::OFS_EXT_REQ) || (s_axi_awaddr == irfb_pkg::OFS_PERIPH_REQ)
		|| (s_axi_awaddr == irfb_pkg::OFS_WAKE_REQ) || (s_axi_awaddr == irfb_pkg::OFS_EDGE_SEL)
		|| (s_axi_awaddr == irfb_pkg::OFS_EXT_PIN_EN) || (s_axi_awaddr == irfb_pkg::OFS_WAKE_PIN_EN);

	// ****************************************
	// request flags
	// ****************************************
	// [R2] [R19] [R4] only a zero write clears; set wins
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			ext_req_flag_o <= irfb_pkg::RST_EXT;
		else if (byte0_wr && s_axi_awaddr == irfb_pkg::OFS_EXT_REQ)
			ext_req_flag_o <= (ext_req_flag_o & ~wr_zero[irfb_pkg::EXT_N-1:0]) | ext_set;
		else
			ext_req_flag_o <= ext_req_flag_o | ext_set;
	end

	// [R21] [R3] [R19] clear-only word
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			peripheral_request_o <= irfb_pkg::RST_REG;
		else if (byte0_wr && s_axi_awaddr == irfb_pkg::OFS_PERIPH_REQ)
			peripheral_request_o <= (peripheral_request_o & ~wr_zero) | per_set;
		else
			peripheral_request_o <= peripheral_request_o | per_set;
	end

	// [R21] [R15] [R3] clear-only word
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			wakeup_request_o <= irfb_pkg::RST_REG;
		else if (byte0_wr && s_axi_awaddr == irfb_pkg::OFS_WAKE_REQ)
			wakeup_request_o <= (wakeup_request_o & ~wr_zero) | wk_set;
		else
			wakeup_request_o <= wakeup_request_o | wk_set;
	end

	// ****************************************
	// configuration
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			edge_sel_r <= irfb_pkg::RST_EXT;
			ext_pin_en_r <= irfb_pkg::RST_EXT;
			wake_pin_en_r <= irfb_pkg::RST_REG;
		end
		else if (byte0_wr)
		begin
			if (s_axi_awaddr == irfb_pkg::OFS_EDGE_SEL)
				edge_sel_r <= s_axi_wdata[irfb_pkg::EXT_N-1:0];
			if (s_axi_awaddr == irfb_pkg::OFS_EXT_PIN_EN)
				ext_pin_en_r <= s_axi_wdata[irfb_pkg::EXT_N-1:0];
			if (s_axi_awaddr == irfb_pkg::OFS_WAKE_PIN_EN)
				wake_pin_en_r <= s_axi_wdata[irfb_pkg::WK_N-1:0];
		end
	end

	// ****************************************
	// bus handshakes
	// ****************************************
	// both write channels taken together, one write in flight
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= irfb_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? irfb_pkg::RESP_OKAY : irfb_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			s_axi_arready <= 1'b0;
		else
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	end

	// ****************************************
	// read mux
	// ****************************************
	// [R16] fixed one at bit 5
	always_comb
	begin
		ext_word = irfb_pkg::RST_REG;
		ext_word[irfb_pkg::EXT_N-1:0] = ext_req_flag_o;
		ext_word[irfb_pkg::BIT_EXT_FIXED] = 1'b1;
	end

	always_comb
	begin
		rd_word = '0;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			irfb_pkg::OFS_EXT_REQ: rd_word[irfb_pkg::REG_W-1:0] = ext_word;
			irfb_pkg::OFS_PERIPH_REQ: rd_word[irfb_pkg::REG_W-1:0] = peripheral_request_o;
			irfb_pkg::OFS_WAKE_REQ: rd_word[irfb_pkg::REG_W-1:0] = wakeup_request_o;
			irfb_pkg::OFS_EDGE_SEL: rd_word[irfb_pkg::EXT_N-1:0] = edge_sel_r;
			irfb_pkg::OFS_EXT_PIN_EN: rd_word[irfb_pkg::EXT_N-1:0] = ext_pin_en_r;
			irfb_pkg::OFS_WAKE_PIN_EN: rd_word[irfb_pkg::WK_N-1:0] = wake_pin_en_r;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= irfb_pkg::RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? irfb_pkg::RESP_OKAY : irfb_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence s_per_wr;
		byte0_wr && s_axi_awaddr == irfb_pkg::OFS_PERIPH_REQ;
	endsequence

	sequence s_wk_wr;
		byte0_wr && s_axi_awaddr == irfb_pkg::OFS_WAKE_REQ;
	endsequence

	// [R1] external set
	a_ext_edge_set: assert property ((|ext_set) |=> ((ext_req_flag_o & $past(ext_set)) == $past(ext_set))) // [R1]
		else $error("external flag missed its edge");
	// [R17] edge select
	a_edge_select: assert property ((ext_pin_en_r[0] && !edge_sel_r[0] && ext_rise[0] && !ext_req_flag_o[0]
		&& !(byte0_wr && s_axi_awaddr == irfb_pkg::OFS_EXT_REQ)) |=> !ext_req_flag_o[0]) // [R17]
		else $error("rising edge set a falling-select flag");
	// [R2] clear by zero
	a_ext_clear: assert property ((byte0_wr && s_axi_awaddr == irfb_pkg::OFS_EXT_REQ && !s_axi_wdata[0]
		&& !ext_set[0]) |=> !ext_req_flag_o[0]) // [R2]
		else $error("external flag not cleared by zero");
	// [R3] one never sets
	a_no_write_set: assert property ((s_per_wr and (per_set == '0) and (peripheral_request_o == '0))
		|=> peripheral_request_o == '0) // [R3]
		else $error("write set a peripheral flag");
	// [R4] hold without clear
	a_flag_hold: assert property ((peripheral_request_o[irfb_pkg::BIT_TB] && !(byte0_wr
		&& s_axi_awaddr == irfb_pkg::OFS_PERIPH_REQ && !s_axi_wdata[irfb_pkg::BIT_TB])) |=> peripheral_request_o[irfb_pkg::BIT_TB]) // [R4]
		else $error("flag dropped without clear");
	// [R19] set beats clear
	a_set_wins: assert property ((s_wk_wr and (wk_set[3] && !s_axi_wdata[3])) |=> wakeup_request_o[3]) // [R19]
		else $error("clear beat a same-cycle set");
	// [R15] wakeup clear
	a_wake_clear: assert property ((s_wk_wr and (!s_axi_wdata[7] && !wk_set[7])) |=> !wakeup_request_o[7]) // [R15]
		else $error("wakeup flag not cleared");
	// [R14] wakeup set
	a_wake_set: assert property (wk_set[0] |=> wakeup_request_o[0]) // [R14]
		else $error("wakeup flag missed falling edge");
	// [R11] timer f low mode gate
	a_tfl_mode: assert property ((timer_f_16bit_i && !peripheral_request_o[irfb_pkg::BIT_TFL])
		|=> !peripheral_request_o[irfb_pkg::BIT_TFL]) // [R11]
		else $error("timer f low set in 16-bit mode");
	// [R16] fixed bit reads one
	a_fixed_bit: assert property ((rd_fire && s_axi_araddr == irfb_pkg::OFS_EXT_REQ)
		|=> s_axi_rvalid && s_axi_rdata[irfb_pkg::BIT_EXT_FIXED]) // [R16]
		else $error("fixed bit did not read one");
	// [R20] one edge, one pulse
	a_one_pulse: assert property (ext_fall[2] |=> !ext_fall[2]) // [R20]
		else $error("edge pulse lasted two cycles");
endmodule

// file: design/irfb_pkg.sv
// ****************************************
// request flag bank constants
// ****************************************
package irfb_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int EXT_N = 5;
	localparam int WK_N = 8;
	localparam int REG_W = 8;

	// byte addresses of the register words
	localparam logic [ADDR_W-1:0] OFS_EXT_REQ = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PERIPH_REQ = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_WAKE_REQ = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_EDGE_SEL = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_EXT_PIN_EN = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_WAKE_PIN_EN = 8'h14;

	// peripheral request bit positions
	localparam int BIT_DT = 7;
	localparam int BIT_AD = 6;
	localparam int BIT_S2 = 5;
	localparam int BIT_TG = 4;
	localparam int BIT_TFH = 3;
	localparam int BIT_TFL = 2;
	localparam int BIT_TC = 1;
	localparam int BIT_TB = 0;

	// fixed-one bit of the external request word
	localparam int BIT_EXT_FIXED = 5;

	localparam logic [EXT_N-1:0] RST_EXT = 5'h00;
	localparam logic [REG_W-1:0] RST_REG = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: design/irfb_pin_sync.sv
`timescale 1ns/1ns
// ****************************************
// pin synchroniser and edge detector
// ****************************************
module irfb_pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// raw pins
	input wire logic [W-1:0] pin_i,
	// one-cycle edge pulses
	output logic [W-1:0] rise_o,
	output logic [W-1:0] fall_o
);
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++)
		begin : g_bit
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic lvl_r;
			always_ff @(posedge sys_clk_i or negedge nrst_i)
			begin
				if (!nrst_i)
				begin
					s1_r <= 1'b1;
					s2_r <= 1'b1;
					s3_r <= 1'b1;
				end
				else
				begin
					s1_r <= pin_i[gi];
					s2_r <= s1_r;
					s3_r <= s2_r;
				end
			end
			// stage one feeds only stage two; a change counts once two and three agree
			always_ff @(posedge sys_clk_i or negedge nrst_i)
			begin
				if (!nrst_i)
					lvl_r <= 1'b1;
				else if (s2_r == s3_r)
					lvl_r <= s3_r;
			end
			assign rise_o[gi] = (s2_r == s3_r) && s3_r && !lvl_r;
			assign fall_o[gi] = (s2_r == s3_r) && !s3_r && lvl_r;
		end
	endgenerate
endmodule

// file: testbench/irfb_evt_model.sv
`timescale 1ns/1ns
// ****
// peripheral event source
// ****
module irfb_evt_model (
	// clock
	input wire logic sys_clk_i,
	// command from the bench
	input wire logic go_i,
	input wire logic [3:0] sel_i,
	// one-cycle event strobes
	output logic [10:0] ev_o
);
	logic go_r = 1'b0;
	logic [3:0] sel_r = 4'h0;

	// events only on command
	// so a clear never meets a new request by chance
	always_ff @(posedge sys_clk_i)
	begin
		go_r <= go_i;
		sel_r <= sel_i;
	end

	assign ev_o = go_r ? (11'h001 << sel_r) : 11'h000;
endmodule

// file: testbench/tb_irfb_top.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_irfb_top;
	// ****
	// stimulus and observation
	// ****
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	// responses are always accepted at once
	logic bready = 1'b1;
	logic rready = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [4:0] ext_pin = 5'h1f;
	logic [7:0] wk_pin = 8'hff;
	// {transfer on, start flag, tg pin enable, 16-bit mode}
	logic [3:0] lvl = 4'h0;
	logic go = 1'b0;
	logic [3:0] sel = 4'h0;
	logic [10:0] ev;
	logic [4:0] ext_flag;
	logic [7:0] per_flag, wk_flag;
	logic [33:0] expq [$];
	logic [33:0] got_e;
	int failures = 0;
	int n_compared = 0;
	// {event, levels, expected word}
	logic [15:0] tbl [17] = '{16'h0880, 16'h0000, 16'h1040, 16'h1400, 16'h2020, 16'h3020, 16'h4210, 16'h4000,
		16'h5008, 16'h5100, 16'h7108, 16'h7000, 16'h6004, 16'h6100, 16'h8002, 16'h9002, 16'ha001};

	irfb_evt_model evm (.sys_clk_i(sys_clk_i), .go_i(go), .sel_i(sel), .ev_o(ev));

	irfb_top DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .ext_request_pin_n_i(ext_pin), .wakeup_pin_n_i(wk_pin),
		.direct_transfer_on_i(lvl[3]), .sleep_transfer_i(ev[0]), .conv_done_i(ev[1]),
		.conversion_start_flag_i(lvl[2]), .serial_two_done_i(ev[2]), .serial_two_abort_i(ev[3]),
		.timer_g_input_pin_en_i(lvl[1]), .timer_g_edge_i(ev[4]), .timer_f_16bit_i(lvl[0]),
		.counter_f_high_match_i(ev[5]), .counter_f_low_match_i(ev[6]), .counter_f_full_match_i(ev[7]),
		.timer_c_overflow_i(ev[8]), .timer_c_underflow_i(ev[9]), .timer_b_overflow_i(ev[10]),
		.ext_req_flag_o(ext_flag), .peripheral_request_o(per_flag), .wakeup_request_o(wk_flag));

	initial
	begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	function automatic logic [33:0] okv(input logic [7:0] v);
		return {2'h0, 24'h0, v};
	endfunction

	// ****
	// bus tasks, entered right after a rising edge
	// ****
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		do @(posedge sys_clk_i); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge sys_clk_i); while (!bvalid);
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		expq.push_back(e);
		arvalid <= 1'b1;
		araddr <= a;
		do @(posedge sys_clk_i); while (!arready);
		arvalid <= 1'b0;
		do @(posedge sys_clk_i); while (!rvalid);
	endtask

	task automatic fire(input logic [3:0] s);
		go <= 1'b1;
		sel <= s;
		@(posedge sys_clk_i);
		go <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
	endtask

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// read results checked against the oldest note
	always @(posedge sys_clk_i)
	begin
		if (rvalid && rready)
		begin
			got_e = expq.pop_front();
			`CHK("read word", got_e, {rresp, rdata})
		end
	end

	initial
	begin
		#300000;
		failures++;
		$display("watchdog expired");
		test_done();
	end

	// ****
	// test sequence
	// ****
	initial
	begin
		int i;
		logic [7:0] e, m, c;
		void'($urandom(32'hb5c3));
		repeat (6) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		@(posedge sys_clk_i);
		rd(8'h00, okv(8'h20));
		rd(8'h04, okv(8'h00));
		rd(8'h08, okv(8'h00));
		rd(8'h18, {2'h2, 32'h0});
		wr(8'h04, 32'hff);
		rd(8'h04, okv(8'h00));
		$display("test reset done");
		for (i = 0; i < 17; i++)
		begin
			wr(8'h04, 32'h0);
			lvl <= tbl[i][11:8];
			fire(tbl[i][15:12]);
			rd(8'h04, okv(tbl[i][7:0]));
		end
		lvl <= 4'b1010;
		for (i = 0; i < 11; i++)
			fire(i[3:0]);
		wr(8'h04, 32'hff);
		rd(8'h04, okv(8'hff));
		c = 8'($urandom());
		wr(8'h04, {24'h0, c});
		rd(8'h04, okv(c));
		$display("test peripheral done");
		e = 8'($urandom());
		// pin zero falls-selected so a rising edge must leave it clear
		e[0] = 1'b0;
		wr(8'h0c, {27'h0, e[4:0]});
		wr(8'h10, 32'h1f);
		ext_pin <= 5'h00;
		repeat (8) @(posedge sys_clk_i);
		rd(8'h00, okv({3'b001, ~e[4:0]}));
		wr(8'h00, 32'h0);
		ext_pin <= 5'h1f;
		repeat (8) @(posedge sys_clk_i);
		rd(8'h00, okv({3'b001, e[4:0]}));
		wr(8'h00, 32'h0);
		rd(8'h00, okv(8'h20));
		$display("test external done");
		m = 8'($urandom());
		wr(8'h14, {24'h0, m});
		wk_pin <= 8'h00;
		repeat (8) @(posedge sys_clk_i);
		rd(8'h08, okv(m));
		c = 8'($urandom());
		wr(8'h08, {24'h0, c});
		rd(8'h08, okv(m & c));
		wk_pin <= 8'hff;
		repeat (8) @(posedge sys_clk_i);
		rd(8'h08, okv(m & c));
		// falling edge timed to land on the clearing write
		wr(8'h14, 32'hff);
		wk_pin <= 8'hf7;
		repeat (2) @(posedge sys_clk_i);
		wr(8'h08, 32'h0);
		rd(8'h08, okv(8'h08));
		$display("test wakeup done");
		repeat (4) @(posedge sys_clk_i);
		test_done();
	end
endmodule
